// *** src/ppt_pkg.sv ***
package ppt_pkg;
   localparam logic [3:0]  CMD_MEM_RD    = 4'h6;
   localparam logic [3:0]  CMD_MEM_WR    = 4'h7;
   localparam logic [3:0]  CMD_CFG_RD    = 4'hA;
   localparam logic [3:0]  CMD_CFG_WR    = 4'hB;
   // command register bits
   localparam int          CMD_MEM_EN    = 1;
   localparam int          CMD_MST_EN    = 2;
   localparam int          CMD_PERR_EN   = 6;
   localparam int          CMD_SERR_EN   = 8;
   localparam logic [15:0] CMD_WMASK     = 16'h0146;
   localparam logic [15:0] CMD_RESET     = 16'h0000;
   // status register bits, write one to clear
   localparam int          ST_DPE_REP    = 8;
   localparam int          ST_RCV_MA     = 13;
   localparam int          ST_SIG_SERR   = 14;
   localparam int          ST_DET_PERR   = 15;
   localparam logic [15:0] ST_RESET      = 16'h0000;
   // config dword indexes
   localparam logic [5:0]  CFG_ID        = 6'h00;
   localparam logic [5:0]  CFG_CMDST     = 6'h01;
   localparam logic [5:0]  CFG_BAR0      = 6'h04;
   localparam int          BAR_LSB       = 12;
   localparam logic [19:0] BAR_RESET     = 20'h00000;
   // arbitrary identity values
   localparam logic [15:0] VENDOR_ID     = 16'h1234;
   localparam logic [15:0] DEVICE_ID     = 16'h5678;
   // master abort after this many clocks without a claim
   localparam logic [2:0]  MA_CLKS       = 3'h5;
   typedef enum {M_IDLE, M_REQ, M_ADDR, M_DATA, M_WLOAD, M_END} ppt_mst_e;
   typedef enum {T_IDLE, T_ACC, T_USR, T_DRV, T_DONE, T_HOLD, T_REL} ppt_tgt_e;
endpackage : ppt_pkg

// *** src/ppt_parity.sv ***
`timescale 1ns/1ps
`default_nettype none
module ppt_parity
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic [31:0] ad,
   input  wire logic [3:0]  cbe_n,
   output var  logic        par_reg
);
   // even parity of the bus as seen at each edge, ready one clock later
   always_ff @(posedge mclk or posedge rst)
      if (rst)
         par_reg <= 1'b0;
      else
         par_reg <= ^{ad, cbe_n};
endmodule : ppt_parity
`default_nettype wire

// *** src/ppt_pci_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module ppt_pci_port
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic [31:0] ad_in,
   output var  logic [31:0] ad_out,
   output var  logic        ad_oe,
   input  wire logic [3:0]  cbe_n_in,
   output var  logic [3:0]  cbe_n_out,
   output var  logic        cbe_oe,
   input  wire logic        par_in,
   output var  logic        par_out,
   output var  logic        par_oe,
   input  wire logic        frame_n_in,
   output var  logic        frame_n_out,
   output var  logic        frame_oe,
   input  wire logic        irdy_n_in,
   output var  logic        irdy_n_out,
   output var  logic        irdy_oe,
   input  wire logic        trdy_n_in,
   output var  logic        trdy_n_out,
   output var  logic        trdy_oe,
   input  wire logic        devsel_n_in,
   output var  logic        devsel_n_out,
   output var  logic        devsel_oe,
   input  wire logic        stop_n_in,
   output var  logic        stop_n_out,
   output var  logic        stop_oe,
   output var  logic        perr_n_out,
   output var  logic        perr_oe,
   output var  logic        serr_n_out,
   output var  logic        serr_oe,
   output var  logic        inta_n_out,
   output var  logic        inta_oe,
   output var  logic        req_n,
   input  wire logic        gnt_n,
   input  wire logic        idsel,
   input  wire logic        irq_req,
   output var  logic        t_req,
   output var  logic        t_we,
   output var  logic [11:0] t_addr,
   output var  logic [31:0] t_wdata,
   output var  logic [3:0]  t_be,
   input  wire logic [31:0] t_rdata,
   input  wire logic        t_ack,
   input  wire logic        m_start,
   input  wire logic        m_we,
   input  wire logic [31:0] m_addr,
   input  wire logic [7:0]  m_len,
   input  wire logic [31:0] m_wdata,
   output var  logic [7:0]  m_idx,
   output var  logic [31:0] m_rdata,
   output var  logic        m_rvalid,
   output var  logic        m_done,
   output var  logic        m_abort,
   output var  logic        m_local
);
   import ppt_pkg::*;

   ppt_mst_e    mst_reg;
   ppt_tgt_e    tgt_reg;
   logic [15:0] cmd_reg;
   logic [15:0] st_reg;
   logic [15:0] st_clr_reg;
   logic [19:0] bar_reg;
   logic        bus_idle_reg;
   logic        mwe_reg;
   logic [31:0] maddr_reg;
   logic [7:0]  left_reg;
   logic [2:0]  dcnt_reg;
   logic        ma_reg;
   logic [3:0]  tcmd_reg;
   logic [31:0] rdata_reg;
   logic        chk_data_reg;
   logic        chk_mst_reg;
   logic        chk_addr_reg;
   logic        par_calc;
   logic        addr_phase;
   logic        m_go;
   logic        tgt_rd;
   logic        rx_done;
   logic        perr_hit;
   logic        aperr_hit;

   function automatic logic bar_hit(input logic [31:0] a);
      bar_hit = (a[31:BAR_LSB] == bar_reg) && cmd_reg[CMD_MEM_EN];
   endfunction : bar_hit

   function automatic logic [31:0] cfg_read(input logic [5:0] idx);
      if (idx == CFG_ID)
         cfg_read = {DEVICE_ID, VENDOR_ID};
      else if (idx == CFG_CMDST)
         cfg_read = {st_reg, cmd_reg};
      else if (idx == CFG_BAR0)
         cfg_read = {bar_reg, 12'h000};
      else
         cfg_read = 32'h00000000;
   endfunction : cfg_read

   ppt_parity u_par
   (
      .mclk    (mclk),
      .rst     (rst),
      .ad      (ad_in),
      .cbe_n   (cbe_n_in),
      .par_reg (par_calc)
   );
   assign par_out = par_calc;

   // own master in its address phase must not be claimed by own target
   assign addr_phase = !frame_n_in && bus_idle_reg && (mst_reg != M_ADDR);
   assign m_go = (mst_reg == M_REQ) && !gnt_n && frame_n_in && irdy_n_in
                 && (tgt_reg == T_IDLE);
   assign tgt_rd = !tcmd_reg[0];
   assign rx_done = ((tgt_reg == T_DONE) && !tgt_rd)
                    || ((mst_reg == M_DATA) && !trdy_n_in && !mwe_reg);
   assign perr_hit = chk_data_reg && (par_calc != par_in);
   assign aperr_hit = chk_addr_reg && (par_calc != par_in);

   always_ff @(posedge mclk or posedge rst)
      if (rst)
         bus_idle_reg <= 1'b1;
      else
         bus_idle_reg <= frame_n_in && irdy_n_in;

   // initiator
   always_ff @(posedge mclk or posedge rst)
      if (rst)
      begin
         mst_reg     <= M_IDLE;
         req_n       <= 1'b1;
         frame_n_out <= 1'b1;
         frame_oe    <= 1'b0;
         irdy_n_out  <= 1'b1;
         irdy_oe     <= 1'b0;
         cbe_n_out   <= 4'hF;
         cbe_oe      <= 1'b0;
         mwe_reg     <= 1'b0;
         maddr_reg   <= 32'h00000000;
         left_reg    <= 8'h00;
         dcnt_reg    <= 3'h0;
         ma_reg      <= 1'b0;
         m_idx       <= 8'h00;
         m_rdata     <= 32'h00000000;
         m_rvalid    <= 1'b0;
         m_done      <= 1'b0;
         m_abort     <= 1'b0;
         m_local     <= 1'b0;
      end
      else
      begin
         m_rvalid <= 1'b0;
         m_done   <= 1'b0;
         m_abort  <= 1'b0;
         m_local  <= 1'b0;
         if (dcnt_reg < MA_CLKS)
            dcnt_reg <= dcnt_reg + 3'h1;
         case (mst_reg)
            M_IDLE:
            begin
               // parked grant drives ad/cbe, and par a clock later; see the data path block
               cbe_n_out <= 4'h0;
               cbe_oe    <= !gnt_n && frame_n_in && irdy_n_in
                            && (tgt_reg == T_IDLE);
               if (m_start && cmd_reg[CMD_MST_EN])
               begin
                  mwe_reg   <= m_we;
                  maddr_reg <= m_addr;
                  left_reg  <= m_len;
                  m_idx     <= 8'h00;
                  if (bar_hit(m_addr))
                  begin
                     m_local <= 1'b1;
                     m_done  <= 1'b1;
                  end
                  else
                  begin
                     req_n   <= 1'b0;
                     mst_reg <= M_REQ;
                  end
               end
            end
            M_REQ:
               if (m_go)
               begin
                  req_n       <= 1'b1;
                  frame_n_out <= 1'b0;
                  frame_oe    <= 1'b1;
                  irdy_n_out  <= 1'b1;
                  irdy_oe     <= 1'b1;
                  cbe_n_out   <= mwe_reg ? CMD_MEM_WR : CMD_MEM_RD;
                  cbe_oe      <= 1'b1;
                  dcnt_reg    <= 3'h1;
                  ma_reg      <= 1'b0;
                  mst_reg     <= M_ADDR;
               end
            M_ADDR:
            begin
               cbe_n_out   <= 4'h0;
               irdy_n_out  <= 1'b0;
               frame_n_out <= (left_reg == 8'h01);
               mst_reg     <= M_DATA;
            end
            M_DATA:
               if (!trdy_n_in)
               begin
                  left_reg <= left_reg - 8'h01;
                  m_idx    <= m_idx + 8'h01;
                  m_rdata  <= ad_in;
                  m_rvalid <= !mwe_reg;
                  if (frame_n_out)
                  begin
                     irdy_n_out <= 1'b1;
                     m_done     <= 1'b1;
                     mst_reg    <= M_END;
                  end
                  else if (!stop_n_in)
                     frame_n_out <= 1'b1;
                  else if (mwe_reg)
                  begin
                     // one wait per write word gives the user a clock
                     irdy_n_out <= 1'b1;
                     mst_reg    <= M_WLOAD;
                  end
                  else if (left_reg == 8'h02)
                     frame_n_out <= 1'b1;
               end
               else if (!stop_n_in || ma_reg)
               begin
                  if (frame_n_out)
                  begin
                     irdy_n_out <= 1'b1;
                     m_done     <= 1'b1;
                     m_abort    <= ma_reg;
                     mst_reg    <= M_END;
                  end
                  else
                     frame_n_out <= 1'b1;
               end
               else if (devsel_n_in && (dcnt_reg == MA_CLKS))
               begin
                  ma_reg      <= 1'b1;
                  frame_n_out <= 1'b1;
               end
            M_WLOAD:
            begin
               irdy_n_out  <= 1'b0;
               frame_n_out <= (left_reg == 8'h01);
               mst_reg     <= M_DATA;
            end
            M_END:
            begin
               frame_oe <= 1'b0;
               irdy_oe  <= 1'b0;
               cbe_oe   <= 1'b0;
               mst_reg  <= M_IDLE;
            end
            default:
               mst_reg <= M_IDLE;
         endcase
      end

   // target
   always_ff @(posedge mclk or posedge rst)
      if (rst)
      begin
         tgt_reg      <= T_IDLE;
         devsel_n_out <= 1'b1;
         devsel_oe    <= 1'b0;
         trdy_n_out   <= 1'b1;
         trdy_oe      <= 1'b0;
         stop_n_out   <= 1'b1;
         stop_oe      <= 1'b0;
         tcmd_reg     <= 4'h0;
         rdata_reg    <= 32'h00000000;
         cmd_reg      <= CMD_RESET;
         bar_reg      <= BAR_RESET;
         st_clr_reg   <= 16'h0000;
         t_req        <= 1'b0;
         t_we         <= 1'b0;
         t_addr       <= 12'h000;
         t_wdata      <= 32'h00000000;
         t_be         <= 4'h0;
      end
      else
      begin
         t_req      <= 1'b0;
         st_clr_reg <= 16'h0000;
         case (tgt_reg)
            T_IDLE:
               if (addr_phase
                   && ((((cbe_n_in == CMD_MEM_RD) || (cbe_n_in == CMD_MEM_WR))
                        && bar_hit(ad_in))
                       || (((cbe_n_in == CMD_CFG_RD)
                            || (cbe_n_in == CMD_CFG_WR))
                           && idsel && (ad_in[1:0] == 2'b00))))
               begin
                  devsel_n_out <= 1'b0;
                  devsel_oe    <= 1'b1;
                  trdy_oe      <= 1'b1;
                  stop_oe      <= 1'b1;
                  tcmd_reg     <= cbe_n_in;
                  t_addr       <= ad_in[11:0];
                  tgt_reg      <= T_ACC;
               end
            T_ACC:
               if (!irdy_n_in)
               begin
                  t_we    <= tcmd_reg[0];
                  t_wdata <= ad_in;
                  t_be    <= ~cbe_n_in;
                  if (tcmd_reg[3])
                  begin
                     rdata_reg <= cfg_read(t_addr[7:2]);
                     tgt_reg   <= T_DRV;
                     if (tcmd_reg[0] && (t_addr[7:2] == CFG_CMDST))
                     begin
                        if (!cbe_n_in[0])
                           cmd_reg[7:0] <= ad_in[7:0] & CMD_WMASK[7:0];
                        if (!cbe_n_in[1])
                           cmd_reg[15:8] <= ad_in[15:8] & CMD_WMASK[15:8];
                        st_clr_reg <= ad_in[31:16]
                                      & {{8{!cbe_n_in[3]}}, {8{!cbe_n_in[2]}}};
                     end
                     if (tcmd_reg[0] && (t_addr[7:2] == CFG_BAR0))
                     begin
                        if (!cbe_n_in[3])
                           bar_reg[19:12] <= ad_in[31:24];
                        if (!cbe_n_in[2])
                           bar_reg[11:4] <= ad_in[23:16];
                        if (!cbe_n_in[1])
                           bar_reg[3:0] <= ad_in[15:12];
                     end
                  end
                  else
                  begin
                     t_req   <= 1'b1;
                     tgt_reg <= T_USR;
                  end
               end
            T_USR:
               if (t_ack)
               begin
                  rdata_reg <= t_rdata;
                  tgt_reg   <= T_DRV;
               end
            T_DRV:
            begin
               trdy_n_out <= 1'b0;
               stop_n_out <= frame_n_in;
               tgt_reg    <= T_DONE;
            end
            T_DONE:
            begin
               trdy_n_out <= 1'b1;
               if (!frame_n_in)
                  tgt_reg <= T_HOLD;
               else
               begin
                  devsel_n_out <= 1'b1;
                  stop_n_out   <= 1'b1;
                  tgt_reg      <= T_REL;
               end
            end
            T_HOLD:
               if (frame_n_in)
               begin
                  devsel_n_out <= 1'b1;
                  stop_n_out   <= 1'b1;
                  tgt_reg      <= T_REL;
               end
            T_REL:
            begin
               devsel_oe <= 1'b0;
               trdy_oe   <= 1'b0;
               stop_oe   <= 1'b0;
               tgt_reg   <= T_IDLE;
            end
            default:
               tgt_reg <= T_IDLE;
         endcase
      end

   // shared address/data drivers
   always_ff @(posedge mclk or posedge rst)
      if (rst)
      begin
         ad_out <= 32'h00000000;
         ad_oe  <= 1'b0;
         par_oe <= 1'b0;
      end
      else
      begin
         par_oe <= ad_oe;
         if ((tgt_reg == T_DRV) && tgt_rd)
         begin
            ad_out <= rdata_reg;
            ad_oe  <= 1'b1;
         end
         else if (tgt_reg == T_DONE)
            ad_oe <= 1'b0;
         else if (m_go)
         begin
            ad_out <= maddr_reg;
            ad_oe  <= 1'b1;
         end
         else if ((mst_reg == M_ADDR) || (mst_reg == M_WLOAD))
         begin
            ad_out <= m_wdata;
            ad_oe  <= mwe_reg;
         end
         else if (mst_reg == M_END)
            ad_oe <= 1'b0;
         else if (mst_reg == M_IDLE)
         begin
            ad_out <= 32'h00000000;
            ad_oe  <= !gnt_n && frame_n_in && irdy_n_in
                      && (tgt_reg == T_IDLE);
         end
      end

   // parity error and system error reporting
   always_ff @(posedge mclk or posedge rst)
      if (rst)
      begin
         chk_data_reg <= 1'b0;
         chk_mst_reg  <= 1'b0;
         chk_addr_reg <= 1'b0;
         perr_n_out   <= 1'b1;
         perr_oe      <= 1'b0;
         serr_n_out   <= 1'b0;
         serr_oe      <= 1'b0;
      end
      else
      begin
         chk_data_reg <= rx_done;
         chk_mst_reg  <= mst_reg == M_DATA;
         chk_addr_reg <= !frame_n_in && bus_idle_reg;
         if (perr_hit && cmd_reg[CMD_PERR_EN])
         begin
            perr_n_out <= 1'b0;
            perr_oe    <= 1'b1;
         end
         else if (!perr_n_out)
            perr_n_out <= 1'b1; // drive high once before release
         else
            perr_oe <= 1'b0;
         // any cycle's address parity, not just ours
         serr_oe <= aperr_hit && cmd_reg[CMD_SERR_EN]
                    && cmd_reg[CMD_PERR_EN];
      end

   // status flags: a new event beats a clear in the same clock
   always_ff @(posedge mclk or posedge rst)
      if (rst)
         st_reg <= ST_RESET;
      else
      begin
         st_reg <= st_reg & ~st_clr_reg;
         if (perr_hit || aperr_hit)
            st_reg[ST_DET_PERR] <= 1'b1;
         if (perr_hit && chk_mst_reg && cmd_reg[CMD_PERR_EN])
            st_reg[ST_DPE_REP] <= 1'b1;
         if (serr_oe)
            st_reg[ST_SIG_SERR] <= 1'b1;
         if (m_abort)
            st_reg[ST_RCV_MA] <= 1'b1;
      end

   always_ff @(posedge mclk or posedge rst)
      if (rst)
      begin
         inta_n_out <= 1'b0;
         inta_oe    <= 1'b0;
      end
      else
         inta_oe <= irq_req;

   AST_RESET_QUIET:
   assert property (@(posedge mclk) $fell(rst) |-> !ad_oe && !frame_oe
                    && !devsel_oe && !trdy_oe && !perr_oe && !par_oe
                    && req_n)
      else $error("bus driven right after reset");
   AST_PAR_FOLLOWS:
   assert property (@(posedge mclk) disable iff (rst)
                    ad_oe |=> par_oe ##0 (^{$past(ad_in), $past(cbe_n_in),
                    par_out}) == 1'b0)
      else $error("parity not even one clock after driven phase");
   AST_PERR_ENABLED:
   assert property (@(posedge mclk) disable iff (rst)
                    $fell(perr_n_out) |-> $past(cmd_reg[CMD_PERR_EN]))
      else $error("parity error driven while disabled");
   AST_CLAIM:
   assert property (@(posedge mclk) disable iff (rst)
                    (tgt_reg == T_ACC) |-> devsel_oe && !devsel_n_out)
      else $error("accepted cycle not claimed");
   AST_MABORT:
   assert property (@(posedge mclk) disable iff (rst)
                    (mst_reg == M_DATA) && (dcnt_reg == MA_CLKS)
                    && devsel_n_in && trdy_n_in && stop_n_in && !ma_reg
                    |=> frame_n_out ##1 irdy_n_out ##0 m_abort)
      else $error("no master abort after unclaimed cycle");
   AST_REQ_HELD:
   assert property (@(posedge mclk) disable iff (rst)
                    (mst_reg == M_REQ) |-> !req_n)
      else $error("bus wanted but request released");
   AST_NO_LOCAL_BUS:
   assert property (@(posedge mclk) disable iff (rst)
                    m_local |-> (mst_reg == M_IDLE) && req_n && !frame_oe)
      else $error("internal transfer touched the bus");
   AST_INTA_OD:
   assert property (@(posedge mclk) disable iff (rst)
                    !inta_n_out
                    && ($past(rst) || (inta_oe == $past(irq_req))))
      else $error("interrupt line not open drain");
   AST_SERR_PULSE:
   assert property (@(posedge mclk) disable iff (rst)
                    serr_oe |-> !serr_n_out ##1 st_reg[ST_SIG_SERR])
      else $error("system error pulse not recorded");
   AST_WAIT_STATE:
   assert property (@(posedge mclk) disable iff (rst)
                    (mst_reg == M_DATA) && trdy_n_in |=> $stable(m_idx))
      else $error("data phase counted without target ready");
endmodule : ppt_pci_port
`default_nettype wire

// *** verification/ppt_far_target.sv ***
`timescale 1ns/1ps
`default_nettype none
module ppt_far_target
(
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic frame_n,
   input  wire logic irdy_n,
   input  wire logic claim,
   output var  logic sel_n
);
   logic fr_q;
   // sel_n stands for both device select and target ready: no waits
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         fr_q  <= 1'b1;
         sel_n <= 1'b1;
      end
      else
      begin
         fr_q <= frame_n;
         if (sel_n && fr_q && !frame_n && claim)
            sel_n <= 1'b0;
         else if (!sel_n && !irdy_n && frame_n)
            sel_n <= 1'b1;
      end
   end
endmodule : ppt_far_target
`default_nettype wire

// *** verification/pci_target_initiator_port_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module pci_target_initiator_port_bench;
   import ppt_pkg::*;
   logic mclk = 0, rst = 1, idsel = 0, irq_req = 1, gnt_n = 1, m_start = 0;
   logic tf = 1, ti = 1, toe = 0, tpar = 0, pclaim = 0, sel_n;
   logic [3:0] tcbe = 4'hF, cbe_b, cbe_n_out;
   logic [31:0] tad = 0, prd = 0, junk = 0, ad_b, ad_out, m_addr = 0;
   logic [31:0] m_rdata, rd, bar;
   logic ad_oe, cbe_oe, par_oe, par_out, frame_oe, frame_n_out, irdy_oe;
   logic irdy_n_out, trdy_oe, trdy_n_out, devsel_oe, devsel_n_out, req_n;
   logic stop_oe, perr_oe, serr_oe, inta_oe, inta_n_out, m_rvalid, m_done;
   logic m_abort, m_local, hit, pbad = 0, perr_seen = 0;
   logic [7:0] mlen = 8'h01;
   logic [31:0] expq[$];
   int fails = 0, comparisons = 0;
   always #2.5 mclk = ~mclk;
   // released lines show a changing pattern, control lines their pull-up
   assign ad_b = ad_oe ? ad_out : !sel_n ? prd : toe ? tad : junk;
   assign cbe_b = cbe_oe ? cbe_n_out : tcbe;
   // parity of what stood before the edge, pbad spoils it on purpose
   always @(posedge mclk)
   begin
      tpar <= ^{ad_b, cbe_b} ^ pbad;
      #1 gnt_n = req_n;
      junk = ~junk;
   end
   ppt_far_target u_far (.mclk(mclk), .rst(rst),
      .frame_n(frame_oe ? frame_n_out : tf),
      .irdy_n(irdy_oe ? irdy_n_out : ti), .claim(pclaim), .sel_n(sel_n));
   ppt_pci_port dut (.mclk(mclk), .rst(rst), .ad_in(ad_b), .ad_out(ad_out),
      .ad_oe(ad_oe), .cbe_n_in(cbe_b), .cbe_n_out(cbe_n_out),
      .cbe_oe(cbe_oe), .par_in(par_oe ? par_out : tpar), .par_out(par_out),
      .par_oe(par_oe), .frame_n_in(frame_oe ? frame_n_out : tf),
      .frame_n_out(frame_n_out), .frame_oe(frame_oe),
      .irdy_n_in(irdy_oe ? irdy_n_out : ti), .irdy_n_out(irdy_n_out),
      .irdy_oe(irdy_oe), .trdy_n_in(trdy_oe ? trdy_n_out : sel_n),
      .trdy_n_out(trdy_n_out), .trdy_oe(trdy_oe),
      .devsel_n_in(devsel_oe ? devsel_n_out : sel_n),
      .devsel_n_out(devsel_n_out), .devsel_oe(devsel_oe), .stop_n_in(1'b1),
      .stop_n_out(), .stop_oe(stop_oe), .perr_n_out(), .perr_oe(perr_oe),
      .serr_n_out(), .serr_oe(serr_oe), .inta_n_out(inta_n_out),
      .inta_oe(inta_oe), .req_n(req_n), .gnt_n(gnt_n), .idsel(idsel),
      .irq_req(irq_req), .t_req(), .t_we(), .t_addr(), .t_wdata(), .t_be(),
      .t_rdata(32'h0), .t_ack(1'b0), .m_start(m_start), .m_we(1'b0),
      .m_addr(m_addr), .m_len(mlen), .m_wdata(32'h0), .m_idx(),
      .m_rdata(m_rdata), .m_rvalid(m_rvalid), .m_done(m_done),
      .m_abort(m_abort), .m_local(m_local));
   task check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check
   task summarize;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : summarize
   // one-phase config cycle driven by the bench as initiator
   task cfg(input logic [3:0] c, input logic [5:0] dw, input logic [31:0] wd,
            input logic sel);
      int n;
      @(posedge mclk) #1;
      {tf, toe, tad, tcbe, idsel} = {2'b01, 24'h0, dw, 2'b00, c, sel};
      @(posedge mclk) #1;
      {tf, ti, tcbe, idsel, toe, tad} = {2'b10, 4'h0, 1'b0, c[0], wd};
      hit = 0;
      for (n = 0; n < 8 && !hit; n++)
      begin
         @(negedge mclk);
         hit = !(trdy_oe ? trdy_n_out : 1'b1);
         rd = ad_b;
      end
      @(posedge mclk) #1;
      {ti, toe, tcbe} = {2'b10, 4'hF};
      repeat (2) @(posedge mclk);
   endtask : cfg
   task mreq(input logic [31:0] a, input logic cl, input logic [1:0] ex);
      int n;
      pclaim = cl;
      prd = $urandom;
      if (ex == 2'b00)
         repeat (mlen)
            expq.push_back(prd);
      expq.push_back({30'h0, ex});
      @(posedge mclk) #1;
      {m_start, m_addr} = {1'b1, a};
      @(posedge mclk) #1;
      m_start = 0;
      for (n = 0; n < 40 && !m_done; n++)
         @(negedge mclk);
      if (n == 40)
      begin
         fails++;
         summarize();
      end
      repeat (4) @(posedge mclk);
      pclaim = 0;
   endtask : mreq
   always @(negedge mclk)
   begin
      if (!rst && m_rvalid)
         check(m_rdata, expq.pop_front());
      if (!rst && m_done)
         check({30'h0, m_abort, m_local}, expq.pop_front());
      if (!rst && perr_oe)
         perr_seen = 1;
   end
   initial
   begin
      void'($urandom(9));
      repeat (10) @(negedge mclk);
      check({ad_oe, cbe_oe, par_oe, frame_oe, irdy_oe, trdy_oe, devsel_oe,
             stop_oe, perr_oe, serr_oe, inta_oe, req_n}, 12'h001);
      @(posedge mclk) #1 rst = 0;
      repeat (3) @(negedge mclk);
      check({inta_oe, inta_n_out}, 2'b10);
      irq_req = 0;
      cfg(CMD_CFG_RD, CFG_ID, 0, 1);
      check(rd, {DEVICE_ID, VENDOR_ID});
      check(inta_oe, 0);
      cfg(CMD_CFG_RD, CFG_ID, 0, 0);
      check(hit, 0);
      cfg(CMD_CFG_WR, CFG_CMDST, 32'hFFFF, 1);
      cfg(CMD_CFG_RD, CFG_CMDST, 0, 1);
      check(rd, {16'h0, CMD_WMASK});
      bar = {4'h4, 28'($urandom)} & 32'hFFFF_F000;
      cfg(CMD_CFG_WR, CFG_BAR0, bar, 1);
      cfg(CMD_CFG_RD, CFG_BAR0, 0, 1);
      check(rd, bar);
      mreq(bar | ($urandom & 32'hFFC), 1, 2'b01);
      mreq(32'h8000_0000 | ($urandom & 32'hFFC), 1, 2'b00);
      mlen = 8'h02;
      mreq(32'h8000_2000 | ($urandom & 32'hFFC), 1, 2'b00);
      mlen = 8'h01;
      mreq(32'h8000_1000, 0, 2'b10);
      check(perr_seen, 0);
      // spoiled parity on a claimed write: address and data both hit
      pbad = 1;
      cfg(CMD_CFG_WR, 6'h02, $urandom, 1);
      pbad = 0;
      check(perr_seen, 1);
      cfg(CMD_CFG_RD, CFG_CMDST, 0, 1);
      check(rd[16 + ST_RCV_MA], 1);
      check(rd[31:16], (16'h1 << ST_DET_PERR) | (16'h1 << ST_SIG_SERR)
                       | (16'h1 << ST_RCV_MA));
      summarize();
   end
endmodule : pci_target_initiator_port_bench
`default_nettype wire
